// ### logic/i2c_flag_defines.svh
// constants for the i2c flag and transfer clock select block
`ifndef I2C_FLAG_DEFINES_SVH
`define I2C_FLAG_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_BUS_FLAG_CH0 32'h0ffffd8a
`define IDX_BUS_FLAG_CH1 32'h0ffffd9a
`define IDX_CLK_SEL_CH0 32'hfffffd84
`define IDX_CLK_SEL_CH1 32'hfffffd94
`define IDX_EXPANSION_CH0 32'h0ffffd8b
`define IDX_EXPANSION_CH1 32'h0ffffd9b
`define IDX_PRESCALER_CH0 32'h0ffffd8c
`define IDX_PRESCALER_CH1 32'h0ffffd9c
`define IDX_CONTROL_CH0 32'h0ffffd8d
`define IDX_CONTROL_CH1 32'h0ffffd9d

// bus flag register fields
`define FLAG_START_CLEAR_BIT 7
`define FLAG_BUS_BUSY_BIT 6
`define FLAG_INIT_START_BIT 1
`define FLAG_RSV_DISABLE_BIT 0

// transfer clock select register fields
`define CLK_LINE_LEVEL_BIT 5
`define DATA_LINE_LEVEL_BIT 4
`define CLK_SPEED_BIT 3
`define CLK_FILTER_BIT 2
`define CLK_SEL_HI_BIT 1
`define CLK_SEL_LO_BIT 0

// expansion, prescaler and control fields
`define EXP_CLOCK_BIT 0
`define PRESCALER_MASK 8'h1b
`define CTL_ENABLE_BIT 0
`define CTL_TRIGGER_BIT 1

// reset values
`define RESET_BYTE 8'h00
`define RESET_LINE 1'b1

// prescaler codes and transfer clock bases, in main clock cycles
`define PRE_CODE_DIV1 8'h18
`define PRE_CODE_DIV2 8'h10
`define PRE_CODE_DIV3 8'h11
`define PRE_CODE_DIV4 8'h12
`define PRE_CODE_DIV5 8'h13
`define BASE_STD_00 9'd44
`define BASE_STD_01 9'd86
`define BASE_STD_10 9'd86
`define BASE_STD_11 9'd66
`define BASE_HS_0X 9'd24
`define BASE_HS_10 9'd24
`define BASE_HS_11 9'd18
`define BASE_HSX_0X 9'd12
`define BASE_HSX_10 9'd12

// digital filter length in samples
`define FILTER_SAMPLES 3

`endif

// ### logic/i2c_flag_pkg.sv
// types for the i2c flag and transfer clock select block
package i2c_flag_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [33:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef enum logic [2:0] {
      KIND_NONE, KIND_FLAG, KIND_CLK, KIND_EXP, KIND_PRE, KIND_CTL
   } reg_kind_t;

   typedef struct packed {
      reg_kind_t kind;
      logic ch;
   } reg_hit_t;

   typedef struct packed {
      logic operation_enable;
      logic start_trigger;
      logic start_clear_flag;
      logic bus_busy_flag;
      logic initial_start_enable;
      logic reservation_disable;
      logic start_permitted;
      logic [3:0] clk_sel;
      logic expansion_clock_bit;
      logic [7:0] prescaler;
      logic start_pulse;
   } channel_t;

endpackage : i2c_flag_pkg

// ### logic/line_sampler.sv
// line level sampling, digital filter and start/stop detection
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"

module line_sampler #(
   parameter int FILTER_LEN = `FILTER_SAMPLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus lines and control
   input wire logic scl,
   input wire logic sda,
   input wire logic filter_on,
   input wire logic run,
   // results
   output logic scl_level,
   output logic sda_level,
   output logic start_det,
   output logic stop_det
);

   typedef struct packed {
      logic [FILTER_LEN-1:0] scl_hist;
      logic [FILTER_LEN-1:0] sda_hist;
      logic scl_lvl;
      logic sda_lvl;
      logic start_det;
      logic stop_det;
   } sampler_state_t;

   sampler_state_t cur, next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.scl_hist = {cur.scl_hist[FILTER_LEN-2:0], scl};
      next_cur.sda_hist = {cur.sda_hist[FILTER_LEN-2:0], sda};
      // filter holds the level until every sample agrees, which costs latency
      if (!filter_on) begin
         next_cur.scl_lvl = scl;
         next_cur.sda_lvl = sda;
      end else begin
         if (&next_cur.scl_hist) next_cur.scl_lvl = 1'b1;
         if (~|next_cur.scl_hist) next_cur.scl_lvl = 1'b0;
         if (&next_cur.sda_hist) next_cur.sda_lvl = 1'b1;
         if (~|next_cur.sda_hist) next_cur.sda_lvl = 1'b0;
      end
      next_cur.start_det = run && cur.scl_lvl && next_cur.scl_lvl &&
                           cur.sda_lvl && !next_cur.sda_lvl;
      next_cur.stop_det = run && cur.scl_lvl && next_cur.scl_lvl &&
                          !cur.sda_lvl && next_cur.sda_lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{scl_hist: '1, sda_hist: '1, scl_lvl: `RESET_LINE,
                  sda_lvl: `RESET_LINE, start_det: 1'b0, stop_det: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign scl_level = cur.scl_lvl;
   assign sda_level = cur.sda_lvl;
   assign start_det = cur.start_det;
   assign stop_det = cur.stop_det;

endmodule : line_sampler

// ### logic/transfer_clock_divider.sv
// transfer clock enable from mode, clock select and prescaler settings
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"

module transfer_clock_divider (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // settings
   input wire logic speed_mode_select,
   input wire logic clock_select_hi,
   input wire logic clock_select_lo,
   input wire logic expansion_clock_bit,
   input wire logic [7:0] prescaler,
   input wire logic run,
   // results
   output logic tick,
   output logic setting_valid
);

   typedef struct packed {
      logic [8:0] count;
      logic tick;
   } divider_state_t;

   divider_state_t cur, next_cur;
   logic [8:0] base;
   logic [2:0] pre;
   logic direct;
   logic [11:0] period;

   always_comb begin
      base = 9'd0;
      direct = 1'b0;
      // the expansion bit picks the faster bases in high-speed mode, except select 11 which gets no base, and leaves standard mode with no base
      unique case ({expansion_clock_bit, speed_mode_select, clock_select_hi,
                    clock_select_lo})
         4'b0000: base = `BASE_STD_00;
         4'b0001: base = `BASE_STD_01;
         4'b0010: begin base = `BASE_STD_10; direct = 1'b1; end
         4'b0011: base = `BASE_STD_11;
         4'b0100, 4'b0101: base = `BASE_HS_0X;
         4'b0110: begin base = `BASE_HS_10; direct = 1'b1; end
         4'b0111: base = `BASE_HS_11;
         4'b1100, 4'b1101: base = `BASE_HSX_0X;
         4'b1110: begin base = `BASE_HSX_10; direct = 1'b1; end
         default: base = 9'd0;
      endcase
      // direct settings ignore the prescaler entirely
      if (direct) pre = 3'd1;
      else begin
         unique case (prescaler)
            `PRE_CODE_DIV1: pre = 3'd1;
            `PRE_CODE_DIV2: pre = 3'd2;
            `PRE_CODE_DIV3: pre = 3'd3;
            `PRE_CODE_DIV4: pre = 3'd4;
            `PRE_CODE_DIV5: pre = 3'd5;
            default: pre = 3'd0;
         endcase
      end
      period = 12'(base) * 12'(pre);
      setting_valid = (period != 12'd0);
      next_cur.tick = 1'b0;
      next_cur.count = 9'd0;
      // the filter bit is not an input here, so its setting never moves the rate
      if (run && setting_valid) begin
         if (12'(cur.count) >= period - 12'd1) next_cur.tick = 1'b1;
         else next_cur.count = cur.count + 9'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{count: 9'd0, tick: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign tick = cur.tick;

   tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick [*8])
      else $error("transfer ticks closer than the shortest period");

endmodule : transfer_clock_divider

// ### logic/i2c_flag_and_clock_select.sv
// bus flag, transfer clock select and expansion registers for two i2c channels
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"

// Summary of operation
// - registers are reached as whole bytes; bit access is a byte read-modify-write.
// - start-clear flag bit 7 and bus-busy flag bit 6 are read-only.
// - reservation and initial-start bits are written only while the channel is disabled.
// - reset loads zero into flag, clock-select and expansion registers of both channels.
// - start-clear flag sets when a refused trigger is dropped without reservation.
// - bus-busy sets on start or on enable without initial start; clears on stop.
// - without initial start, no start is issued until a stop is seen.
// - initial-start bit clears on a detected start and on reset.
// - reservation-disable bit changes only by software write or reset.
// - with initial start set, the bus reads released right after enabling.
// - bit 5 shows the sampled clock line level while enabled.
// - bit 4 shows the sampled data line level while enabled.
// - both level bits read zero while the channel is disabled.
// - bit 3 picks standard mode at zero and high-speed mode at one.
// - bit 2 switches the digital input filter on, in high-speed mode only.
// - the digital filter setting does not change the high-speed transfer rate.
// - transfer clock comes from mode, select bits, expansion bit and prescaler.
// - expansion register acts only in high-speed mode; written whether enabled or not.
// - direct settings use the main clock whatever the prescaler holds.
module i2c_flag_and_clock_select (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire i2c_flag_pkg::apb_req_t apb_req,
   output i2c_flag_pkg::apb_rsp_t apb_rsp,
   // bus lines, taken as synchronous samples
   input wire logic [1:0] serial_clock_pin,
   input wire logic [1:0] serial_data_pin,
   // to the rest of the unit
   output logic [1:0] operation_enable,
   output logic [1:0] start_request,
   output logic [1:0] transfer_tick,
   output logic [1:0] clock_setting_valid
);

   typedef struct packed {
      i2c_flag_pkg::channel_t [1:0] ch;
      logic [31:0] rd_data;
      logic err;
   } block_state_t;

   block_state_t cur, next_cur;
   logic [1:0] scl_level, sda_level, start_det, stop_det;
   logic setup_phase, write_now;
   i2c_flag_pkg::reg_hit_t hit;

   function automatic i2c_flag_pkg::reg_hit_t decode(input logic [33:0] addr);
      i2c_flag_pkg::reg_hit_t h;
      h = '{kind: i2c_flag_pkg::KIND_NONE, ch: 1'b0};
      if (addr[1:0] == 2'b00) begin
         unique case (addr[33:2])
            `IDX_BUS_FLAG_CH0: h = '{kind: i2c_flag_pkg::KIND_FLAG, ch: 1'b0};
            `IDX_BUS_FLAG_CH1: h = '{kind: i2c_flag_pkg::KIND_FLAG, ch: 1'b1};
            `IDX_CLK_SEL_CH0: h = '{kind: i2c_flag_pkg::KIND_CLK, ch: 1'b0};
            `IDX_CLK_SEL_CH1: h = '{kind: i2c_flag_pkg::KIND_CLK, ch: 1'b1};
            `IDX_EXPANSION_CH0: h = '{kind: i2c_flag_pkg::KIND_EXP, ch: 1'b0};
            `IDX_EXPANSION_CH1: h = '{kind: i2c_flag_pkg::KIND_EXP, ch: 1'b1};
            `IDX_PRESCALER_CH0: h = '{kind: i2c_flag_pkg::KIND_PRE, ch: 1'b0};
            `IDX_PRESCALER_CH1: h = '{kind: i2c_flag_pkg::KIND_PRE, ch: 1'b1};
            `IDX_CONTROL_CH0: h = '{kind: i2c_flag_pkg::KIND_CTL, ch: 1'b0};
            `IDX_CONTROL_CH1: h = '{kind: i2c_flag_pkg::KIND_CTL, ch: 1'b1};
            default: h = '{kind: i2c_flag_pkg::KIND_NONE, ch: 1'b0};
         endcase
      end
      return h;
   endfunction : decode

   function automatic logic [7:0] read_byte(input i2c_flag_pkg::reg_hit_t h,
                                            input i2c_flag_pkg::channel_t c,
                                            input logic scl_l,
                                            input logic sda_l);
      logic [7:0] v;
      v = 8'h00;
      unique case (h.kind)
         i2c_flag_pkg::KIND_FLAG: begin
            // bits 5 to 2 stay zero
            v[`FLAG_START_CLEAR_BIT] = c.start_clear_flag;
            v[`FLAG_BUS_BUSY_BIT] = c.bus_busy_flag;
            v[`FLAG_INIT_START_BIT] = c.initial_start_enable;
            v[`FLAG_RSV_DISABLE_BIT] = c.reservation_disable;
         end
         i2c_flag_pkg::KIND_CLK: begin
            v[3:0] = c.clk_sel;
            // levels are gated by enable
            v[`CLK_LINE_LEVEL_BIT] = c.operation_enable && scl_l;
            v[`DATA_LINE_LEVEL_BIT] = c.operation_enable && sda_l;
         end
         i2c_flag_pkg::KIND_EXP: v[`EXP_CLOCK_BIT] = c.expansion_clock_bit;
         i2c_flag_pkg::KIND_PRE: v = c.prescaler;
         i2c_flag_pkg::KIND_CTL: begin
            v[`CTL_ENABLE_BIT] = c.operation_enable;
            v[`CTL_TRIGGER_BIT] = c.start_trigger;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_byte

   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign write_now = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                      apb_req.pstrb[0] && hit.kind != i2c_flag_pkg::KIND_NONE;
   assign hit = decode(apb_req.paddr);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         line_sampler #(.FILTER_LEN(`FILTER_SAMPLES)) u_sampler (
            .pclk(pclk),
            .presetn(presetn),
            .scl(serial_clock_pin[gi]),
            .sda(serial_data_pin[gi]),
            // filter only in high-speed mode
            .filter_on(cur.ch[gi].clk_sel[`CLK_FILTER_BIT] &&
                       cur.ch[gi].clk_sel[`CLK_SPEED_BIT]),
            .run(cur.ch[gi].operation_enable),
            .scl_level(scl_level[gi]),
            .sda_level(sda_level[gi]),
            .start_det(start_det[gi]),
            .stop_det(stop_det[gi])
         );
         transfer_clock_divider u_divider (
            .pclk(pclk),
            .presetn(presetn),
            .speed_mode_select(cur.ch[gi].clk_sel[`CLK_SPEED_BIT]),
            .clock_select_hi(cur.ch[gi].clk_sel[`CLK_SEL_HI_BIT]),
            .clock_select_lo(cur.ch[gi].clk_sel[`CLK_SEL_LO_BIT]),
            // expansion bit dropped in standard mode
            .expansion_clock_bit(cur.ch[gi].expansion_clock_bit &&
                                 cur.ch[gi].clk_sel[`CLK_SPEED_BIT]),
            .prescaler(cur.ch[gi].prescaler),
            .run(cur.ch[gi].operation_enable),
            .tick(transfer_tick[gi]),
            .setting_valid(clock_setting_valid[gi])
         );
      end
   endgenerate

   always_comb begin
      next_cur = cur;
      if (setup_phase) begin
         next_cur.err = (hit.kind == i2c_flag_pkg::KIND_NONE);
         next_cur.rd_data = {24'h000000, read_byte(hit, cur.ch[hit.ch],
                             scl_level[hit.ch], sda_level[hit.ch])};
      end
      for (int i = 0; i < 2; i++) begin
         next_cur.ch[i].start_pulse = 1'b0;
         // whole-byte writes on lane 0 only; bit writes arrive as bytes
         if (write_now && hit.ch == 1'(i)) begin
            unique case (hit.kind)
               i2c_flag_pkg::KIND_FLAG: begin
                  // bits 7 to 2 are never stored
                  if (!cur.ch[i].operation_enable) begin
                     next_cur.ch[i].initial_start_enable = apb_req.pwdata[`FLAG_INIT_START_BIT];
                     next_cur.ch[i].reservation_disable = apb_req.pwdata[`FLAG_RSV_DISABLE_BIT];
                  end
               end
               i2c_flag_pkg::KIND_CLK: next_cur.ch[i].clk_sel = apb_req.pwdata[3:0];
               i2c_flag_pkg::KIND_EXP:
                  next_cur.ch[i].expansion_clock_bit = apb_req.pwdata[`EXP_CLOCK_BIT];
               i2c_flag_pkg::KIND_PRE:
                  next_cur.ch[i].prescaler = apb_req.pwdata[7:0] & `PRESCALER_MASK;
               i2c_flag_pkg::KIND_CTL: begin
                  next_cur.ch[i].operation_enable = apb_req.pwdata[`CTL_ENABLE_BIT];
                  if (apb_req.pwdata[`CTL_TRIGGER_BIT] && apb_req.pwdata[`CTL_ENABLE_BIT]) begin
                     next_cur.ch[i].start_trigger = 1'b1;
                     next_cur.ch[i].start_clear_flag = 1'b0;
                  end
               end
               default: next_cur.ch[i].start_pulse = 1'b0;
            endcase
         end
         if (!cur.ch[i].operation_enable && next_cur.ch[i].operation_enable) begin
            // enable: busy unless initial start was allowed
            next_cur.ch[i].bus_busy_flag = !cur.ch[i].initial_start_enable;
            next_cur.ch[i].start_permitted = cur.ch[i].initial_start_enable;
         end
         if (cur.ch[i].operation_enable) begin
            if (start_det[i]) begin
               next_cur.ch[i].bus_busy_flag = 1'b1;
               next_cur.ch[i].initial_start_enable = 1'b0;
            end else if (stop_det[i]) begin
               next_cur.ch[i].bus_busy_flag = 1'b0;
               next_cur.ch[i].start_permitted = 1'b1;
            end
            // a pending trigger either issues, waits reserved, or is dropped
            if (cur.ch[i].start_trigger) begin
               if (cur.ch[i].start_permitted && !cur.ch[i].bus_busy_flag) begin
                  next_cur.ch[i].start_pulse = 1'b1;
                  next_cur.ch[i].start_trigger = 1'b0;
               end else if (cur.ch[i].reservation_disable) begin
                  next_cur.ch[i].start_trigger = 1'b0;
                  next_cur.ch[i].start_clear_flag = 1'b1;
               end
            end
         end
         if (!next_cur.ch[i].operation_enable) begin
            // disable wipes the run state
            next_cur.ch[i].start_trigger = 1'b0;
            next_cur.ch[i].start_clear_flag = 1'b0;
            next_cur.ch[i].bus_busy_flag = 1'b0;
            next_cur.ch[i].start_permitted = 1'b0;
            next_cur.ch[i].start_pulse = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0; // every register byte resets to zero
      end else begin
         cur <= next_cur;
      end
   end

   // zero wait states: read data is captured in the setup cycle
   assign apb_rsp.prdata = cur.rd_data;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && cur.err;
   assign operation_enable = {cur.ch[1].operation_enable, cur.ch[0].operation_enable};
   assign start_request = {cur.ch[1].start_pulse, cur.ch[0].start_pulse};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   enable_busy_a: assert property ($rose(cur.ch[0].operation_enable) |->
      cur.ch[0].bus_busy_flag == !$past(cur.ch[0].initial_start_enable))
      else $error("busy flag wrong after enable");
   stop_release_a: assert property (cur.ch[0].operation_enable && stop_det[0] &&
      !start_det[0] && next_cur.ch[0].operation_enable |=> !cur.ch[0].bus_busy_flag)
      else $error("stop did not release the bus");
   start_busy_a: assert property (cur.ch[0].operation_enable && start_det[0] &&
      next_cur.ch[0].operation_enable |=> cur.ch[0].bus_busy_flag &&
      !cur.ch[0].initial_start_enable)
      else $error("start did not mark busy or clear initial start");
   disable_clear_a: assert property (!cur.ch[0].operation_enable |->
      !cur.ch[0].bus_busy_flag && !cur.ch[0].start_clear_flag &&
      !cur.ch[0].start_trigger)
      else $error("flags not cleared while disabled");
   level_gate_a: assert property (setup_phase && hit.kind == i2c_flag_pkg::KIND_CLK &&
      !hit.ch && !cur.ch[0].operation_enable |=> cur.rd_data[5:4] == 2'b00)
      else $error("line levels visible while disabled");
   locked_bits_a: assert property (cur.ch[0].operation_enable |=>
      $stable(cur.ch[0].reservation_disable) && !$rose(cur.ch[0].initial_start_enable))
      else $error("locked flag bits changed while enabled");
   drop_trigger_a: assert property (cur.ch[0].operation_enable &&
      cur.ch[0].start_trigger && cur.ch[0].bus_busy_flag &&
      cur.ch[0].reservation_disable && !write_now ##1 cur.ch[0].operation_enable
      |-> cur.ch[0].start_clear_flag && !cur.ch[0].start_trigger)
      else $error("refused trigger not dropped with flag");
   issue_start_a: assert property (cur.ch[1].operation_enable && cur.ch[1].start_trigger &&
      cur.ch[1].start_permitted && !cur.ch[1].bus_busy_flag && !write_now |=>
      cur.ch[1].start_pulse ##1 !cur.ch[1].start_pulse)
      else $error("start not issued as a single pulse");
   hold_reserve_a: assert property (cur.ch[1].operation_enable && cur.ch[1].start_trigger &&
      cur.ch[1].bus_busy_flag && !cur.ch[1].reservation_disable && !write_now |=>
      cur.ch[1].start_trigger && !cur.ch[1].start_pulse)
      else $error("reserved trigger lost");
   unmapped_err_a: assert property (setup_phase && hit.kind == i2c_flag_pkg::KIND_NONE
      ##1 apb_req.psel && apb_req.penable |-> apb_rsp.pslverr && apb_rsp.pready)
      else $error("unmapped access not flagged");
   flag_zeros_a: assert property (setup_phase && hit.kind == i2c_flag_pkg::KIND_FLAG |=>
      cur.rd_data[5:2] == 4'h0 && cur.rd_data[31:8] == 24'h000000)
      else $error("unused flag bits read back set");
   init_only_sw_a: assert property (!(write_now && hit.kind == i2c_flag_pkg::KIND_FLAG) |=>
      !$rose(cur.ch[0].initial_start_enable))
      else $error("initial start set without a write");
   rsv_only_sw_a: assert property (!(write_now && hit.kind == i2c_flag_pkg::KIND_FLAG) |=>
      $stable(cur.ch[0].reservation_disable))
      else $error("reservation bit changed without a write");
   busy_cause_a: assert property (cur.ch[0].operation_enable && !cur.ch[0].bus_busy_flag &&
      !start_det[0] |=> !cur.ch[0].bus_busy_flag)
      else $error("busy set without a start");
   enable_busy1_a: assert property ($rose(cur.ch[1].operation_enable) |->
      cur.ch[1].bus_busy_flag == !$past(cur.ch[1].initial_start_enable))
      else $error("channel 1 busy flag wrong after enable");
   pulse_free1_a: assert property (cur.ch[1].start_pulse |->
      $past(cur.ch[1].start_permitted) && !$past(cur.ch[1].bus_busy_flag))
      else $error("channel 1 start issued on a busy bus");
   unmapped_zero_a: assert property (setup_phase && hit.kind == i2c_flag_pkg::KIND_NONE |=>
      cur.rd_data == 32'h00000000)
      else $error("unmapped read returned data");

   issue_c: cover property (cur.ch[1].start_pulse);
   dropped_c: cover property ($rose(cur.ch[0].start_clear_flag));
   reserved_c: cover property (cur.ch[1].start_trigger [*4] ##1 cur.ch[1].start_pulse);
   stop_c: cover property (cur.ch[0].operation_enable && stop_det[0]);

endmodule : i2c_flag_and_clock_select

// ### testbench/i2c_far_end.sv
// far end of the i2c bus: another master making start and stop conditions
`timescale 1ns/100ps
module i2c_far_end (
   // clock
   input wire logic pclk,
   // lines, pulled high when released
   output logic [1:0] scl,
   output logic [1:0] sda
);
   initial begin
      scl = 2'b11;
      sda = 2'b11;
   end
   task automatic start(input int ch);
      @(posedge pclk) sda[ch] <= 1'b0; // data falls while clock high
      repeat (3) @(posedge pclk);
      scl[ch] <= 1'b0;
   endtask : start
   task automatic stop(input int ch);
      @(posedge pclk) sda[ch] <= 1'b0;
      @(posedge pclk) scl[ch] <= 1'b1;
      repeat (3) @(posedge pclk);
      sda[ch] <= 1'b1; // data rises while clock high, bus free
   endtask : stop
endmodule : i2c_far_end

// ### testbench/tb.sv
// self-checking bench for the flag and transfer clock select block
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
   localparam logic [31:0] f0 = `IDX_BUS_FLAG_CH0;
   localparam logic [31:0] f1 = `IDX_BUS_FLAG_CH1;
   localparam logic [31:0] c0 = `IDX_CLK_SEL_CH0;
   localparam logic [31:0] p0 = `IDX_PRESCALER_CH0;
   localparam logic [31:0] k0 = `IDX_CONTROL_CH0;
   localparam logic [31:0] k1 = `IDX_CONTROL_CH1;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   i2c_flag_pkg::apb_req_t req = '0;
   i2c_flag_pkg::apb_rsp_t rsp;
   logic [1:0] scl, sda, oen, sreq, tick, cvalid;
   int n_fail = 0;
   int compares = 0;
   int n_start = 0;
   logic [7:0] q;
   logic e;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (sreq[1] === 1'b1) n_start <= n_start + 1;
   i2c_far_end i_far (.pclk(pclk), .scl(scl), .sda(sda));
   i2c_flag_and_clock_select i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .serial_clock_pin(scl), .serial_data_pin(sda), .operation_enable(oen),
      .start_request(sreq), .transfer_tick(tick), .clock_setting_valid(cvalid));
   task automatic tally_and_finish();
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // request held from setup until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [31:0] idx, input logic [7:0] d);
      int k = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00},
               pwdata: {24'h0, d}, pstrb: 4'h1};
      @(posedge pclk) req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 50);
      q = rsp.prdata[7:0];
      e = rsp.pslverr;
      if (rsp.pready !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer
   task automatic rd(input string nm, input logic [31:0] idx, input logic [7:0] ex);
      xfer(1'b0, idx, 8'h00);
      `CHK(nm, ex, q)
   endtask : rd
   // gap between two ticks of channel 0, counted at falling edges
   task automatic period(input int ex);
      int n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (tick[0] !== 1'b1 && n < 400);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (tick[0] !== 1'b1 && n < 400);
      if (tick[0] !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      `CHK("tick gap", ex, n)
   endtask : period
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("flag0", f0, 8'h00);
      rd("flag1", f1, 8'h00);
      rd("clksel0", c0, 8'h00);
      rd("exp0", `IDX_EXPANSION_CH0, 8'h00);
      xfer(1'b1, f0, 8'hff);
      rd("flag0", f0, 8'h03);
      xfer(1'b1, c0, 8'h3f);
      rd("clksel0", c0, 8'h0f);
      `CHK("setting valid", 2'b00, cvalid)
      xfer(1'b1, k0, 8'h01);
      rd("flag0", f0, 8'h03);
      rd("clksel0", c0, 8'h3f);
      xfer(1'b1, f0, 8'h00);
      rd("flag0", f0, 8'h03);
      i_far.start(0);
      repeat (8) @(posedge pclk);
      rd("flag0", f0, 8'h41);
      rd("clksel0", c0, 8'h0f);
      i_far.stop(0);
      repeat (8) @(posedge pclk);
      rd("flag0", f0, 8'h01);
      i_far.start(0);
      repeat (8) @(posedge pclk);
      xfer(1'b1, k0, 8'h03);
      repeat (4) @(posedge pclk);
      rd("flag0", f0, 8'hc1);
      i_far.stop(0);
      xfer(1'b1, k0, 8'h00);
      rd("flag0", f0, 8'h01);
      rd("clksel0", c0, 8'h0f);
      // channel 1: reservation on, no initial start, trigger waits for a stop
      xfer(1'b1, k1, 8'h01);
      rd("flag1", f1, 8'h40);
      xfer(1'b1, k1, 8'h03);
      repeat (8) @(posedge pclk);
      `CHK("start before stop", 0, n_start)
      i_far.stop(1);
      repeat (10) @(posedge pclk);
      `CHK("start after stop", 1, n_start)
      xfer(1'b1, c0, 8'h08);
      xfer(1'b1, p0, 8'h18);
      xfer(1'b1, k0, 8'h01);
      period(24);
      `CHK("setting valid", 2'b01, cvalid)
      `CHK("enable", 2'b11, oen)
      xfer(1'b1, k0, 8'h00);
      xfer(1'b1, c0, 8'h0c);
      xfer(1'b1, k0, 8'h01);
      period(24);
      xfer(1'b1, k0, 8'h00);
      xfer(1'b1, `IDX_EXPANSION_CH0, 8'h01);
      rd("exp0", `IDX_EXPANSION_CH0, 8'h01);
      xfer(1'b1, c0, 8'h02);
      xfer(1'b1, p0, 8'h00);
      xfer(1'b1, k0, 8'h01);
      period(86);
      xfer(1'b1, k0, 8'h00);
      xfer(1'b1, c0, 8'h08);
      xfer(1'b1, p0, 8'h18);
      xfer(1'b1, k0, 8'h01);
      period(12);
      xfer(1'b0, 32'h00000001, 8'h00);
      `CHK("slverr", 1'b1, e)
      tally_and_finish();
   end
endmodule : tb
